// *** src/trap_vec_map.svh ***
// register offsets, field positions, trap numbers and codes of the trap vectoring block
`ifndef TRAP_VEC_MAP_SVH
`define TRAP_VEC_MAP_SVH
`define OFS_REQ       8'h00
`define OFS_ENABLE    8'h04
`define OFS_LEVEL     8'h08
`define OFS_CAUSE     8'h0C
`define OFS_SWTRAP    8'h10
`define OFS_STATE     8'h14
`define OFS_IRQ_STAT  8'h18
`define OFS_IRQ_MASK  8'h1C
`define TRAP_RESET    7'h00
`define TRAP_NMI      7'h02
`define TRAP_STACK_OVER  7'h04
`define TRAP_STACK_UNDER 7'h06
`define TRAP_CLASS_B  7'h0A
`define CLASS_NONE    2'h0
`define CLASS_I       2'h1
`define CLASS_II      2'h2
`define CLASS_III     2'h3
`define SRC_TRAPS     56'h8F_0D_FA_B5_08_22_32
`define IRQ_HW_TRAP   0
`define IRQ_TAKEN     1
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// *** src/trap_vec_pkg.sv ***
// types shared by the trap vectoring block
package trap_vec_pkg;
    // one offered vector: trap number, table location, priority class
    typedef struct packed {
        logic [6:0] trap;
        logic [8:0] loc;
        logic [1:0] pclass;
    } vector_type;
    // hardware trap events, bit order equals the cause flag layout
    typedef struct packed {
        logic [4:0] class_b;
        logic       stack_underflow;
        logic       stack_overflow;
        logic       nmi;
    } trap_event_type;
    // whole block state
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        arready;
        logic        aw_full;
        logic        w_full;
        logic        bvalid;
        logic        rvalid;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
        logic [7:0]  aw_addr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [31:0] rdata;
        logic [7:0]  req;
        logic [7:0]  en;
        logic [31:0] level;
        logic [7:0]  cause;
        logic        reset_p;
        logic        nmi_p;
        logic        stack_over_p;
        logic        stack_under_p;
        logic        class_b_p;
        logic        sw_p;
        logic [6:0]  sw_num;
        logic        vec_valid;
        logic        vec_int;
        logic [2:0]  vec_src;
        vector_type  vec;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        irq;
    } state_type;
endpackage

// *** src/interrupt_trap_vectoring.sv ***
// interrupt and trap vectoring unit with AXI4-Lite register slave
// Contract
// - each source has request flag, enable flag and fixed trap number/vector
// - hardware traps branch to their own vector, no mask suppresses them
// - each hardware trap sets its own bit in the cause flags
// - hardware trap preempts anything except a higher trap service
// - no interrupt or event transfer enters during a trap service
// - all resets vector to location 0, trap 00h, class III
// - class A: nmi 02h, stack overflow 04h, underflow 06h, class II
// - class B traps share trap 0Ah at 028h, class I
// - illegal external bus access raises class B and its own flag
// - software trap takes any number 00h-7Fh at current cpu priority
// - each source programmed to one of sixteen levels
// - only a strictly higher level interrupts a running service
`timescale 1ns/1ps
`default_nettype none
`include "trap_vec_map.svh"
module interrupt_trap_vectoring (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [7:0]                    awaddr,
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic [1:0]                         bresp,
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [7:0]                    araddr,
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    input  wire logic [7:0]                    src_event,
    input  wire trap_vec_pkg::trap_event_type  hw_traps,
    input  wire logic                          sw_reset,
    input  wire logic                          wdt_overflow,
    input  wire logic [3:0]                    cpu_level,
    input  wire logic [1:0]                    cpu_trap_class,
    input  wire logic                          vec_ack,
    output logic                               vec_valid,
    output trap_vec_pkg::vector_type           vec,
    output logic                               irq
);
    localparam logic [55:0] SRC_TRAPS = `SRC_TRAPS;

    trap_vec_pkg::state_type s;
    trap_vec_pkg::state_type next_s;
    logic [3:0]              granted_lvl;

    // offer a vector and derive its location
    function automatic trap_vec_pkg::vector_type mk_vec(input logic [6:0] t,
                                                        input logic [1:0] c);
        mk_vec.trap   = t;
        mk_vec.loc    = {t, 2'b00};
        mk_vec.pclass = c;
    endfunction

    // next state of bus slave, flags and arbiter
    always_comb begin
        logic [31:0] m;
        logic [31:0] d;
        logic [31:0] rd;
        logic        wr_fire;
        logic        rd_ok;
        logic        best_ok;
        logic [3:0]  best_lvl;
        logic [2:0]  best_i;
        m        = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
        d        = s.wdata & m;
        rd       = 32'h0000_0000;
        rd_ok    = 1'b1;
        wr_fire  = s.aw_full && s.w_full && !s.bvalid;
        best_ok  = 1'b0;
        best_lvl = 4'h0;
        best_i   = 3'h0;
        next_s   = s;
        // address and data taken in either order
        if (awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_full = 1'b1;
            next_s.wdata  = wdata;
            next_s.wstrb  = wstrb;
        end
        if (bready && s.bvalid) begin
            next_s.bvalid = 1'b0;
        end
        if (rready && s.rvalid) begin
            next_s.rvalid = 1'b0;
        end
        // register writes, w1c flags clear here before hardware sets
        if (wr_fire) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = `RESP_OKAY;
            unique case (s.aw_addr)
                `OFS_REQ: next_s.req = s.req & ~d[7:0];
                `OFS_ENABLE: next_s.en = d[7:0] | (s.en & ~m[7:0]);
                `OFS_LEVEL: next_s.level = d | (s.level & ~m);
                `OFS_CAUSE: next_s.cause = s.cause & ~d[7:0];
                `OFS_SWTRAP: begin
                    if (m[0]) begin
                        next_s.sw_p   = 1'b1;
                        next_s.sw_num = s.wdata[6:0];
                    end
                end
                `OFS_STATE: next_s.bresp = `RESP_OKAY;
                `OFS_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~d[1:0];
                `OFS_IRQ_MASK: next_s.irq_mask = d[1:0] | (s.irq_mask & ~m[1:0]);
                default: next_s.bresp = `RESP_SLVERR;
            endcase
        end
        // register reads
        if (arvalid && s.arready) begin
            unique case (araddr)
                `OFS_REQ: rd = {24'h00_0000, s.req};
                `OFS_ENABLE: rd = {24'h00_0000, s.en};
                `OFS_LEVEL: rd = s.level;
                `OFS_CAUSE: rd = {24'h00_0000, s.cause};
                `OFS_SWTRAP: rd = {24'h00_0000, s.sw_p, s.sw_num};
                `OFS_STATE: rd = {4'h0, s.vec_valid, s.vec_int, s.vec_src, s.reset_p,
                                  s.nmi_p, s.stack_over_p, s.stack_under_p, s.class_b_p, s.vec};
                `OFS_IRQ_STAT: rd = {30'h0000_0000, s.irq_stat};
                `OFS_IRQ_MASK: rd = {30'h0000_0000, s.irq_mask};
                default: rd_ok = 1'b0;
            endcase
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd;
            next_s.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        // cpu takes the offered vector
        if (s.vec_valid && vec_ack) begin
            next_s.vec_valid   = 1'b0;
            next_s.irq_stat[`IRQ_TAKEN] = 1'b1;
        end
        // highest enabled source strictly above the cpu level
        for (int i = 0; i < 8; i++) begin
            if (s.req[i] && s.en[i] && s.level[4*i+:4] > cpu_level
                && (!best_ok || s.level[4*i+:4] > best_lvl)) begin
                best_ok  = 1'b1;
                best_lvl = s.level[4*i+:4];
                best_i   = 3'(i);
            end
        end
        // arbitration: reset, class A, class B, software trap, interrupt
        if (!s.vec_valid) begin
            if (s.reset_p) begin
                next_s.reset_p   = 1'b0;
                next_s.vec_valid = 1'b1;
                next_s.vec_int   = 1'b0;
                next_s.vec       = mk_vec(`TRAP_RESET, `CLASS_III);
            end else if (s.nmi_p && `CLASS_II >= cpu_trap_class) begin
                next_s.nmi_p     = 1'b0;
                next_s.vec_valid = 1'b1;
                next_s.vec_int   = 1'b0;
                next_s.vec       = mk_vec(`TRAP_NMI, `CLASS_II);
            end else if (s.stack_over_p && `CLASS_II >= cpu_trap_class) begin
                next_s.stack_over_p  = 1'b0;
                next_s.vec_valid     = 1'b1;
                next_s.vec_int       = 1'b0;
                next_s.vec           = mk_vec(`TRAP_STACK_OVER, `CLASS_II);
            end else if (s.stack_under_p && `CLASS_II >= cpu_trap_class) begin
                next_s.stack_under_p = 1'b0;
                next_s.vec_valid     = 1'b1;
                next_s.vec_int       = 1'b0;
                next_s.vec           = mk_vec(`TRAP_STACK_UNDER, `CLASS_II);
            end else if (s.class_b_p && `CLASS_I >= cpu_trap_class) begin
                next_s.class_b_p = 1'b0;
                next_s.vec_valid = 1'b1;
                next_s.vec_int   = 1'b0;
                next_s.vec       = mk_vec(`TRAP_CLASS_B, `CLASS_I);
            end else if (s.sw_p) begin
                next_s.sw_p      = wr_fire && s.aw_addr == `OFS_SWTRAP && m[0]; // new write wins
                next_s.vec_valid = 1'b1;
                next_s.vec_int   = 1'b0;
                next_s.vec       = mk_vec(s.sw_num, `CLASS_NONE);
            end else if (best_ok && cpu_trap_class == `CLASS_NONE) begin
                next_s.req[best_i] = 1'b0;
                next_s.vec_valid   = 1'b1;
                next_s.vec_int     = 1'b1;
                next_s.vec_src     = best_i;
                next_s.vec         = mk_vec(SRC_TRAPS[7*best_i+:7], `CLASS_NONE);
            end
        end
        // hardware sets last so an event in a clearing cycle survives
        next_s.req   = next_s.req | src_event;
        next_s.cause = next_s.cause | hw_traps;
        if (sw_reset || wdt_overflow) begin
            next_s.reset_p = 1'b1;
        end
        if (hw_traps.nmi) begin
            next_s.nmi_p = 1'b1;
        end
        if (hw_traps.stack_overflow) begin
            next_s.stack_over_p = 1'b1;
        end
        if (hw_traps.stack_underflow) begin
            next_s.stack_under_p = 1'b1;
        end
        if (|hw_traps.class_b) begin
            next_s.class_b_p = 1'b1;
        end
        if (|hw_traps) begin
            next_s.irq_stat[`IRQ_HW_TRAP] = 1'b1;
        end
        // ready and interrupt flops follow the new state
        next_s.awready = !next_s.aw_full && !next_s.bvalid;
        next_s.wready  = !next_s.w_full && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
        next_s.irq     = |(next_s.irq_stat & next_s.irq_mask);
    end

    // state register, reset offers the reset vector first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s         <= '0;
            s.reset_p <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops
    assign awready     = s.awready;
    assign wready      = s.wready;
    assign bvalid      = s.bvalid;
    assign bresp       = s.bresp;
    assign arready     = s.arready;
    assign rvalid      = s.rvalid;
    assign rdata       = s.rdata;
    assign rresp       = s.rresp;
    assign vec_valid   = s.vec_valid;
    assign vec         = s.vec;
    assign irq         = s.irq;
    assign granted_lvl = s.level[4*s.vec_src+:4];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_src_vector;
        $rose(s.vec_valid) && s.vec_int |-> s.vec.trap == SRC_TRAPS[7*s.vec_src+:7]
            && s.vec.loc == {s.vec.trap, 2'b00};
    endproperty
    a_src_vector: assert property (p_src_vector) else $error("source vector wrong");
    property p_nmi_unmasked;
        s.nmi_p && !s.vec_valid && !s.reset_p && cpu_trap_class <= `CLASS_II
            |=> s.vec_valid && s.vec.trap == `TRAP_NMI && s.vec.loc == 9'h008;
    endproperty
    a_nmi_unmasked: assert property (p_nmi_unmasked) else $error("nmi not taken");
    property p_bus_flag;
        hw_traps.class_b[4] |=> s.cause[7] && s.class_b_p || s.vec.pclass == `CLASS_I;
    endproperty
    a_bus_flag: assert property (p_bus_flag) else $error("bus trap flag missing");
    property p_cause_flag;
        hw_traps.stack_overflow |=> s.cause[1];
    endproperty
    a_cause_flag: assert property (p_cause_flag) else $error("cause flag missing");
    property p_trap_preempt;
        $rose(s.vec_valid) && s.vec.pclass != `CLASS_NONE
            |-> s.vec.pclass >= $past(cpu_trap_class);
    endproperty
    a_trap_preempt: assert property (p_trap_preempt) else $error("trap below service");
    property p_no_int_in_trap;
        $rose(s.vec_valid) && s.vec_int |-> $past(cpu_trap_class) == `CLASS_NONE;
    endproperty
    a_no_int_in_trap: assert property (p_no_int_in_trap) else $error("int in trap");
    property p_reset_vector;
        $fell(s.reset_p) |-> s.vec_valid && s.vec.trap == 7'h00 && s.vec.loc == 9'h000
            && s.vec.pclass == 2'h3;
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("reset vector wrong");
    property p_class_b_shared;
        $rose(s.vec_valid) && s.vec.pclass == `CLASS_I
            |-> s.vec.trap == 7'h0A && s.vec.loc == 9'h028;
    endproperty
    a_class_b_shared: assert property (p_class_b_shared) else $error("class b vector");
    property p_sw_trap;
        $rose(s.vec_valid) && !s.vec_int && s.vec.pclass == `CLASS_NONE
            |-> s.vec.trap == $past(s.sw_num) && s.vec.loc == {s.vec.trap, 2'b00};
    endproperty
    a_sw_trap: assert property (p_sw_trap) else $error("software trap vector");
    property p_level_higher;
        $rose(s.vec_valid) && s.vec_int |-> granted_lvl > $past(cpu_level);
    endproperty
    a_level_higher: assert property (p_level_higher) else $error("level not higher");
    property p_offer_holds;
        s.vec_valid && !vec_ack |=> s.vec_valid && $stable(s.vec);
    endproperty
    a_offer_holds: assert property (p_offer_holds) else $error("offer dropped");
endmodule
`default_nettype wire

// *** test/cpu_model.sv ***
// behavioural processor core that takes offered vectors
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      vec_valid,
    input  wire trap_vec_pkg::vector_type  vec,
    input  wire logic [3:0]                delay,
    output logic                           vec_ack,
    output trap_vec_pkg::vector_type       last_vec,
    output logic [7:0]                     taken
);
    logic [3:0] cnt;
    // wait delay cycles on an offer, then ack for one cycle and record it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_ack  <= 1'b0;
            cnt      <= 4'h0;
            taken    <= 8'h00;
            last_vec <= '0;
        end else begin
            vec_ack <= 1'b0;
            if (vec_valid && !vec_ack) begin
                if (cnt >= delay) begin
                    vec_ack  <= 1'b1;
                    last_vec <= vec;
                    taken    <= taken + 8'h01;
                    cnt      <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench of the trap vectoring block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic                         awready, wready, bvalid, arready, rvalid, irq;
    logic                         sw_reset, wdt_overflow, vec_ack, vec_valid;
    logic [7:0]                   awaddr, araddr, src_event, taken, seen;
    logic [31:0]                  wdata, rdata, rd;
    logic [3:0]                   wstrb, cpu_level, delay;
    logic [1:0]                   bresp, rresp, cpu_trap_class, resp;
    trap_vec_pkg::trap_event_type hw_traps;
    trap_vec_pkg::vector_type     vec, last_vec;
    int                           errors, num_checks;

    interrupt_trap_vectoring u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .src_event(src_event), .hw_traps(hw_traps), .sw_reset(sw_reset),
        .wdt_overflow(wdt_overflow), .cpu_level(cpu_level), .cpu_trap_class(cpu_trap_class),
        .vec_ack(vec_ack), .vec_valid(vec_valid), .vec(vec), .irq(irq));
    cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .vec_valid(vec_valid), .vec(vec),
        .delay(delay), .vec_ack(vec_ack), .last_vec(last_vec), .taken(taken));

    // clock
    always #12.5 aclk = ~aclk;

    task end_of_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task give_up();
        errors++;
        $display("wrong value at %0t: wait ran out", $time);
        end_of_test();
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bus write, response code left in resp
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) give_up();
        resp = bresp;
        bready <= 1'b0;
    endtask
    // bus read into rd and resp
    task rd_reg(input logic [7:0] a);
        int n;
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) give_up();
        rd = rdata; resp = rresp;
        rready <= 1'b0;
    endtask
    // wait for the core to take a vector and compare it
    task expect_vec(input logic [6:0] tr, input logic [1:0] pc);
        int n;
        for (n = 0; n < 100 && taken === seen; n++) @(posedge aclk);
        if (taken === seen) give_up();
        seen = taken;
        chk({14'h0, last_vec}, {14'h0, tr, tr, 2'h0, pc});
    endtask
    task expect_none();
        repeat (20) @(posedge aclk);
        chk({24'h0, taken}, {24'h0, seen});
    endtask
    task pulse_src(input int i);
        @(posedge aclk); src_event <= 8'h01 << i;
        @(posedge aclk); src_event <= 8'h00;
    endtask
    task pulse_hw(input logic [7:0] b);
        @(posedge aclk); hw_traps <= trap_vec_pkg::trap_event_type'(b);
        @(posedge aclk); hw_traps <= '0;
    endtask

    task t_sources();
        logic [6:0] tbl [8];
        int i;
        tbl = '{7'h32, 7'h44, 7'h20, 7'h28, 7'h2B, 7'h3F, 7'h43, 7'h47};
        expect_vec(7'h00, 2'h3);
        wr(8'h04, 32'hFF); wr(8'h08, 32'h5555_5555);
        for (i = 0; i < 8; i++) begin
            pulse_src(i);
            expect_vec(tbl[i], 2'h0);
        end
        rd_reg(8'h00); chk(rd, 32'h0);
        cpu_level <= 4'h5; pulse_src(0); expect_none();
        wr(8'h08, 32'h5555_555F); expect_vec(7'h32, 2'h0);
        cpu_level <= 4'h2; cpu_trap_class <= 2'h1; pulse_src(1); expect_none();
        cpu_trap_class <= 2'h0; expect_vec(7'h44, 2'h0);
        $display("sources test finished");
    endtask
    task t_traps();
        int k;
        wr(8'h04, 32'h0); cpu_level <= 4'hF; delay <= 4'h6;
        for (k = 0; k < 8; k++) begin
            pulse_hw(8'h01 << k);
            expect_vec((k < 3) ? 7'(2 * k + 2) : 7'h0A, (k < 3) ? 2'h2 : 2'h1);
            rd_reg(8'h0C); chk(rd, 32'h1 << k);
            wr(8'h0C, 32'h1 << k);
        end
        delay <= 4'h0; cpu_trap_class <= 2'h3; pulse_hw(8'h01); expect_none();
        cpu_trap_class <= 2'h2; expect_vec(7'h02, 2'h2);
        wr(8'h0C, 32'h1); cpu_trap_class <= 2'h0; cpu_level <= 4'h2; wr(8'h04, 32'hFF);
        wr(8'h10, 32'h7F); expect_vec(7'h7F, 2'h0);
        wr(8'h10, 32'h00); expect_vec(7'h00, 2'h0);
        @(posedge aclk); sw_reset <= 1'b1; @(posedge aclk); sw_reset <= 1'b0;
        expect_vec(7'h00, 2'h3);
        @(posedge aclk); wdt_overflow <= 1'b1; @(posedge aclk); wdt_overflow <= 1'b0;
        expect_vec(7'h00, 2'h3);
        $display("traps test finished");
    endtask
    task t_irq_bus();
        wr(8'h1C, 32'h2); repeat (2) @(posedge aclk); chk({31'h0, irq}, 32'h1);
        wr(8'h18, 32'h3); repeat (2) @(posedge aclk); chk({31'h0, irq}, 32'h0);
        pulse_src(2); expect_vec(7'h20, 2'h0);
        repeat (2) @(posedge aclk); chk({31'h0, irq}, 32'h1);
        wr(8'h1C, 32'h0); repeat (2) @(posedge aclk); chk({31'h0, irq}, 32'h0);
        rd_reg(8'h18); chk(rd & 32'h2, 32'h2);
        rd_reg(8'h14); chk(rd, 32'h0501_0200);
        wr(8'h1C, 32'h1); pulse_hw(8'h01); expect_vec(7'h02, 2'h2);
        chk({31'h0, irq}, 32'h1);
        rd_reg(8'h40); chk({30'h0, resp}, 32'h2); chk(rd, 32'h0);
        wr(8'h40, 32'h1); chk({30'h0, resp}, 32'h2);
        $display("irq and bus test finished");
    endtask

    // stimulus
    initial begin
        aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        wstrb = 4'hF; src_event = 8'h00; hw_traps = '0; sw_reset = 1'b0;
        wdt_overflow = 1'b0; cpu_level = 4'h2; cpu_trap_class = 2'h0; delay = 4'h0;
        seen = 8'h00; errors = 0; num_checks = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_sources();
        t_traps();
        t_irq_bus();
        end_of_test();
    end
endmodule
`default_nettype wire
